// File: rtl/timer_output_idle_commut_ctrl.sv
// Timer control-two register: idle levels, input XOR select, commutation preload
// Summary of operation
// - The register resets to zero and reserved bits always read zero.
// - Bit 9 sets the level of complementary output 1 while master output enable is low.
// - Bit 8 sets the level of main output 1 while master output enable is low.
// - Bits 10 to 14, 16 and 18 give the same idle levels for the other main and complementary outputs.
// - Idle-level bits ignore writes while the lock level is 1, 2 or 3.
// - Bit 7 picks channel 1 pin alone or the XOR of pins 1, 2 and 3 as first input.
// - Bit 2 lets a trigger rising edge, not only commutation generate, update controls.
// - Bit 0 holds enable and mode writes until a commutation event.
// - Preload and update select only act on channels with a complementary output.
//
// Local design decision: the address-and-strobe port.
`include "tmr_ctl2_params.svh"
module timer_output_idle_commut_ctrl
  import tmr_ctl2_pkg::*;
#(
  parameter int NUM_CHAN = 6,
  parameter int NUM_COMPL = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire addr_t reg_addr,
  input wire word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output word_t reg_rdata,
  input wire logic [1:0] lock_level,
  input wire logic commutation_generate,
  input wire logic trigger_input,
  input wire logic [2:0] channel_pin,
  output logic first_timer_input,
  output logic [5:0] idle_level_main,
  output logic [2:0] idle_level_compl,
  output logic control_preload_enable,
  output logic com_event_seen,
  output logic [29:0] chan_ctrl_active
);
  typedef struct packed {
    word_t ctl_r;
    word_t rdata_r;
    logic [1:0] trig_sync_r;
    logic trig_prev_r;
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic ti_r;
    logic [5:0] main_r;
    logic [2:0] compl_r;
    logic control_preload_enable_r;
    logic com_r;
    logic com_seen_r;
    logic trig_seen_r;
    logic [29:0] act_r;
  } top_s;

  top_s st_r;
  top_s st_nxt;
  logic [29:0] pre_w;
  logic [29:0] act_w;
  logic com_event;
  logic [NUM_CHAN-1:0] slot_wr;

  // Commutation: software generate, or trigger rise when update select set
  assign com_event = commutation_generate
                   | (st_r.ctl_r[`BIT_UPDATE_SEL]
                      & st_r.trig_sync_r[1] & ~st_r.trig_prev_r);

  // One preload write fans out to every slot, each taking its own lane
  always_comb begin
    slot_wr = '0;
    if (reg_wr && reg_addr == `OFS_CHAN_PRELOAD) begin
      slot_wr = '1;
    end
  end

  // One slot per channel; low channels carry complementary outputs
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      chan_ctrl_slot #(
        .HAS_COMPL(g < NUM_COMPL)
      ) u_slot (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .wr_en(slot_wr[g]),
        .wr_data(reg_wdata[g*`CHAN_CTRL_W +: `CHAN_CTRL_W]),
        .preload_en(st_r.ctl_r[`BIT_PRELOAD_EN]),
        .com_event(com_event),
        .preload_q(pre_w[g*`CHAN_CTRL_W +: `CHAN_CTRL_W]),
        .active_q(act_w[g*`CHAN_CTRL_W +: `CHAN_CTRL_W])
      );
    end
  endgenerate

  // Register writes, read mux, pin sync and output staging
  always_comb begin
    word_t wmask;
    wmask = `MASK_CONTROL_TWO;
    st_nxt = st_r;
    // Locked levels freeze idle bits but still allow the other fields
    if (lock_level != 2'h0) begin
      wmask = wmask & ~`MASK_IDLE_BITS;
    end
    if (reg_wr && reg_addr == `OFS_CONTROL_TWO) begin
      st_nxt.ctl_r = (st_r.ctl_r & ~wmask) | (reg_wdata & wmask);
    end
    // Status flags clear on write of ones; a new event wins over the clear
    if (reg_wr && reg_addr == `OFS_CHAN_STATUS) begin
      if (reg_wdata[`BIT_STAT_COM]) st_nxt.com_seen_r = 1'b0;
      if (reg_wdata[`BIT_STAT_TRIG]) st_nxt.trig_seen_r = 1'b0;
    end
    if (com_event) st_nxt.com_seen_r = 1'b1;
    if (st_r.trig_sync_r[1] & ~st_r.trig_prev_r) st_nxt.trig_seen_r = 1'b1;
    st_nxt.rdata_r = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_CONTROL_TWO: st_nxt.rdata_r = st_r.ctl_r & `MASK_CONTROL_TWO;
        `OFS_CHAN_PRELOAD: st_nxt.rdata_r = {2'h0, pre_w};
        `OFS_CHAN_ACTIVE: st_nxt.rdata_r = {2'h0, act_w};
        `OFS_CHAN_STATUS: st_nxt.rdata_r = {29'h0, st_r.com_seen_r,
                                            st_r.trig_seen_r, st_r.ti_r};
        default: st_nxt.rdata_r = '0;
      endcase
    end
    // Two-stage synchronisers for pins from outside this clock
    st_nxt.trig_sync_r = {st_r.trig_sync_r[0], trigger_input};
    st_nxt.trig_prev_r = st_r.trig_sync_r[1];
    st_nxt.pin_meta_r = channel_pin;
    st_nxt.pin_sync_r = st_r.pin_meta_r;
    st_nxt.ti_r = st_r.ctl_r[`BIT_XOR_SEL] ? ^st_r.pin_sync_r
                                           : st_r.pin_sync_r[0];
    // Idle levels go to the dead-time stage, which applies them when enable drops
    st_nxt.main_r = {st_r.ctl_r[`BIT_IDLE_MAIN_6], st_r.ctl_r[`BIT_IDLE_MAIN_5],
                     st_r.ctl_r[`BIT_IDLE_MAIN_4], st_r.ctl_r[`BIT_IDLE_MAIN_3],
                     st_r.ctl_r[`BIT_IDLE_MAIN_2], st_r.ctl_r[`BIT_IDLE_MAIN_1]};
    st_nxt.compl_r = {st_r.ctl_r[`BIT_IDLE_COMPL_3], st_r.ctl_r[`BIT_IDLE_COMPL_2],
                      st_r.ctl_r[`BIT_IDLE_COMPL_1]};
    st_nxt.control_preload_enable_r = st_r.ctl_r[`BIT_PRELOAD_EN];
    st_nxt.com_r = com_event;
    st_nxt.act_r = act_w;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // All outputs straight from flops
  assign reg_rdata = st_r.rdata_r;
  assign first_timer_input = st_r.ti_r;
  assign idle_level_main = st_r.main_r;
  assign idle_level_compl = st_r.compl_r;
  assign control_preload_enable = st_r.control_preload_enable_r;
  assign com_event_seen = st_r.com_seen_r;
  assign chan_ctrl_active = st_r.act_r;
endmodule : timer_output_idle_commut_ctrl

// File: rtl/tmr_ctl2_params.svh
// Offsets, field positions, masks, the reset value and the channel field width for the timer control-two block
`ifndef TMR_CTL2_PARAMS_SVH
`define TMR_CTL2_PARAMS_SVH
`define OFS_CONTROL_TWO 8'h04
`define OFS_CHAN_PRELOAD 8'h40
`define OFS_CHAN_ACTIVE 8'h44
`define OFS_CHAN_STATUS 8'h48
`define RST_CONTROL_TWO 32'h0000_0000
`define MASK_CONTROL_TWO 32'h0005_7F85
`define MASK_IDLE_BITS 32'h0005_7F00
`define BIT_PRELOAD_EN 0
`define BIT_UPDATE_SEL 2
`define BIT_XOR_SEL 7
`define BIT_IDLE_MAIN_1 8
`define BIT_IDLE_COMPL_1 9
`define BIT_IDLE_MAIN_2 10
`define BIT_IDLE_COMPL_2 11
`define BIT_IDLE_MAIN_3 12
`define BIT_IDLE_COMPL_3 13
`define BIT_IDLE_MAIN_4 14
`define BIT_IDLE_MAIN_5 16
`define BIT_IDLE_MAIN_6 18
`define CHAN_CTRL_W 5
`define BIT_STAT_XOR 0
`define BIT_STAT_TRIG 1
`define BIT_STAT_COM 2
`endif

// File: rtl/tmr_ctl2_pkg.sv
// Types shared by the timer control-two block
package tmr_ctl2_pkg;
  // Per-channel control: enable, complementary enable, 3-bit output mode
  typedef logic [4:0] chan_ctrl_t;
  typedef logic [7:0] addr_t;
  typedef logic [31:0] word_t;
endpackage : tmr_ctl2_pkg

// File: rtl/chan_ctrl_slot.sv
// One channel's preload and active copies of enable and mode bits
module chan_ctrl_slot
  import tmr_ctl2_pkg::*;
#(
  parameter bit HAS_COMPL = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire chan_ctrl_t wr_data,
  input wire logic preload_en,
  input wire logic com_event,
  output chan_ctrl_t preload_q,
  output chan_ctrl_t active_q
);
  typedef struct packed {
    chan_ctrl_t pre_r;
    chan_ctrl_t act_r;
  } slot_s;

  slot_s st_r;
  slot_s st_nxt;

  // Preloading only applies where a complementary output exists
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.pre_r = wr_data;
    end
    if (!(HAS_COMPL && preload_en)) begin
      st_nxt.act_r = st_nxt.pre_r;
    end else if (com_event) begin
      st_nxt.act_r = st_r.pre_r;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign preload_q = st_r.pre_r;
  assign active_q = st_r.act_r;
endmodule : chan_ctrl_slot

// File: tb/tmr_ctl2_props.sv
// Checker for the timer control-two register block
`include "tmr_ctl2_params.svh"
module tmr_ctl2_props
  import tmr_ctl2_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire addr_t reg_addr,
  input wire word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire word_t reg_rdata,
  input wire logic [1:0] lock_level,
  input wire logic commutation_generate,
  input wire logic trigger_input,
  input wire logic [5:0] idle_level_main,
  input wire logic control_preload_enable,
  input wire logic com_event_seen,
  input wire logic [29:0] chan_ctrl_active
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Writes followed by quiet cycles, so the copies can settle
  sequence s_ctl_wr;
    reg_wr && clk_en && reg_addr == 8'h04 && lock_level == 2'h0 ##1 !reg_wr;
  endsequence
  sequence s_chan_wr;
    reg_wr && clk_en && reg_addr == 8'h40 && !control_preload_enable ##1 !reg_wr [*2];
  endsequence
  chk_rdata_quiet: assert property (!$past(reg_rd) && $past(clk_en) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h04 |->
    (reg_rdata & ~`MASK_CONTROL_TWO) == 32'h0) else $error("reserved bit read as one");
  chk_idle_locked: assert property ((lock_level != 2'h0) [*4] |-> $stable(idle_level_main))
    else $error("idle level moved under lock");
  chk_ctl_copy: assert property (s_ctl_wr |-> ##1
    control_preload_enable == $past(reg_wdata[0], 2) && idle_level_main[0] == $past(reg_wdata[8], 2))
    else $error("control copy wrong");
  chk_com_flag: assert property (commutation_generate && clk_en |-> ##2 com_event_seen)
    else $error("commutation not flagged");
  chk_flag_sticky: assert property (com_event_seen && !reg_wr && !$past(reg_wr) |=> com_event_seen)
    else $error("commutation flag lost");
  chk_preload_hold: assert property ((control_preload_enable && !commutation_generate &&
    !trigger_input) [*8] |-> $stable(chan_ctrl_active[14:0])) else $error("preload leaked");
  chk_direct_follow: assert property (s_chan_wr |-> ##1
    chan_ctrl_active == $past(reg_wdata[29:0], 3)) else $error("direct write not applied");
endmodule : tmr_ctl2_props

// File: tb/timer_output_idle_commut_ctrl_tb.sv
// Self-checking bench for the timer control-two register block
module timer_output_idle_commut_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tmr_ctl2_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  addr_t reg_addr = 8'h00;
  word_t reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] lock_level = 2'h0;
  logic commutation_generate = 1'b0;
  logic trigger_input = 1'b0;
  logic [2:0] channel_pin = 3'h3;
  word_t reg_rdata;
  logic first_timer_input, control_preload_enable, com_event_seen;
  logic [5:0] idle_level_main;
  logic [2:0] idle_level_compl;
  logic [29:0] chan_ctrl_active;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Free-running 40 MHz clock
  always #12.5 clk = ~clk;
  timer_output_idle_commut_ctrl timer_output_idle_commut_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_level(lock_level),
    .commutation_generate(commutation_generate), .trigger_input(trigger_input),
    .channel_pin(channel_pin), .first_timer_input(first_timer_input),
    .idle_level_main(idle_level_main), .idle_level_compl(idle_level_compl),
    .control_preload_enable(control_preload_enable), .com_event_seen(com_event_seen),
    .chan_ctrl_active(chan_ctrl_active));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // Bus cycles: one-cycle strobes, read data sampled after the edge that loads it
  task automatic wr(input addr_t a, input word_t d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input addr_t a, input word_t exp);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("read data", reg_rdata, exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic end_of_test();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Cycle ceiling, far above the roughly 70 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0005_7F85);
    check("idle main", 32'(idle_level_main), 32'h3F);
    check("idle compl", 32'(idle_level_compl), 32'h7);
    // Every nonzero lock level must shield the idle bits only
    for (int l = 1; l < 4; l++) begin
      @(posedge clk);
      lock_level <= 2'(l);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h0005_7F00);
    end
    check("pin input", 32'(first_timer_input), 32'h1);
    wr(8'h40, 32'h2AAA_AAAA);
    idle(3);
    check("direct", 32'(chan_ctrl_active), 32'h2AAA_AAAA);
    // Unlocked again, so the idle bits take the written zeros
    lock_level <= 2'h0;
    wr(8'h04, 32'h0000_0081);
    rd(8'h04, 32'h0000_0081);
    idle(3);
    check("xor input", 32'(first_timer_input), 32'h0);
    wr(8'h40, 32'h1555_5555);
    idle(3);
    check("held", 32'(chan_ctrl_active), 32'h1555_2AAA);
    commutation_generate <= 1'b1;
    @(posedge clk);
    commutation_generate <= 1'b0;
    idle(2);
    check("commuted", 32'(chan_ctrl_active), 32'h1555_5555);
    wr(8'h40, 32'h0AAA_AAAA);
    trigger_input <= 1'b1;
    idle(6);
    check("trigger ignored", 32'(chan_ctrl_active), 32'h0AAA_D555);
    trigger_input <= 1'b0;
    wr(8'h04, 32'h0000_0085);
    trigger_input <= 1'b1;
    idle(6);
    check("trigger used", 32'(chan_ctrl_active), 32'h0AAA_AAAA);
    rd(8'h40, 32'h0AAA_AAAA);
    rd(8'h44, 32'h0AAA_AAAA);
    wr(8'h48, 32'h0000_0004);
    idle(2);
    check("flag cleared", 32'(com_event_seen), 32'h0);
    // Trigger flag still set, commutation flag cleared, XOR input low
    rd(8'h48, 32'h0000_0002);
    end_of_test();
  end
endmodule : timer_output_idle_commut_ctrl_tb
bind timer_output_idle_commut_ctrl tmr_ctl2_props tmr_ctl2_props_inst (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_level(lock_level),
  .commutation_generate(commutation_generate), .trigger_input(trigger_input),
  .idle_level_main(idle_level_main), .control_preload_enable(control_preload_enable),
  .com_event_seen(com_event_seen), .chan_ctrl_active(chan_ctrl_active));
